// >>> hw/hbah_pkg.sv
// Purpose: shared constants for the host bus acknowledge handshake
// Assumes: one clock REF_CLK at 125 MHz, pins synchronous to it
// Notes: both ends import this package
package hbah_pkg;
	localparam int REF_CLK_KHZ   = 125000;  // system clock rate
	localparam int FAST_CLK_KHZ  = 58320;   // internal fast clock rate
	localparam int FAST_PER_CORE = 2;       // fast clocks per core cycle
	// core cycle in system clocks, rounded up so no wait falls short
	localparam int CORE_DIV = (FAST_PER_CORE * REF_CLK_KHZ + FAST_CLK_KHZ - 1) / FAST_CLK_KHZ;
	localparam int DIV_W    = $clog2(CORE_DIV);
	localparam int GRPS     = 4;   // group selects
	localparam int AW       = 11;  // address width
	localparam int DW       = 8;   // data width
	localparam int TICK_W   = 7;   // width of wait lengths in core cycles
	// waits in core cycles per target
	localparam logic [TICK_W-1:0] WAIT_REG = 7'h00;
	localparam logic [TICK_W-1:0] WAIT_IRD = 7'h06;
	localparam logic [TICK_W-1:0] WAIT_DRD = 7'h09;
	localparam logic [TICK_W-1:0] WAIT_IWR = 7'h05;
	localparam logic [TICK_W-1:0] WAIT_DWR = 7'h09;
	localparam logic [TICK_W-1:0] WAIT_THR = 7'h61;
	// address regions taken from the top address bits
	localparam int         REGION_LSB  = 9;
	localparam logic [1:0] REGION_IMEM = 2'h2;
	localparam logic [1:0] REGION_DRAM = 2'h3;
	// host pacing times
	localparam int HOST_WAIT_NS = 640;
	localparam int HOST_GAP_NS  = 600;
	localparam int FRAME_NS     = 125000;
	localparam int HOST_WAIT_CYC = (HOST_WAIT_NS * REF_CLK_KHZ + 999999) / 1000000;
	localparam int HOST_GAP_CYC  = (HOST_GAP_NS * REF_CLK_KHZ + 999999) / 1000000;
	localparam int FRAME_CYC     = int'((longint'(FRAME_NS) * REF_CLK_KHZ) / 1000000);
	localparam int FRAME_ACCESS_MAX = 16;
	localparam int HW_W = $clog2(HOST_WAIT_CYC + 1);
	localparam int HG_W = $clog2(HOST_GAP_CYC + 1);
	// access target, one-hot
	typedef enum logic [2:0] {
		TGT_REG  = 3'b001,
		TGT_IMEM = 3'b010,
		TGT_DRAM = 3'b100
	} hbah_target_e;
endpackage

// >>> hw/hbah_if.sv
// Purpose: pin bundle between host and device ends
// Assumes: pins synchronous to REF_CLK
// Notes: resolves shared data and acknowledge wires from enables
`timescale 1ns/1ps
interface hbah_if import hbah_pkg::*; ();
	logic [GRPS-1:0] group_select_n;      // per group select, low active
	logic            lower_data_strobe_n; // data strobe, low active
	logic            read_not_write;      // high read, low write
	logic [AW-1:0]   address;             // word address
	logic [DW-1:0]   host_data;           // host drive value
	logic            host_data_oe;        // host drives data
	logic [DW-1:0]   dev_data;            // device drive value
	logic            dev_data_oe;         // device drives data
	logic            dev_ack;             // device acknowledge level
	logic [GRPS-1:0] dev_ack_oe;          // device drives that ack
	wire  [DW-1:0]   data_bus;            // resolved data
	wire  [GRPS-1:0] transfer_ack_n;      // resolved acks, pulled up
	// undriven bus floats high like a pulled-up line
	assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : {DW{1'b1}});
	assign transfer_ack_n = ~dev_ack_oe | {GRPS{dev_ack}};
	modport dev (
		input  group_select_n, lower_data_strobe_n, read_not_write, address, data_bus,
		output dev_data, dev_data_oe, dev_ack, dev_ack_oe
	);
	modport host (
		output group_select_n, lower_data_strobe_n, read_not_write, address, host_data, host_data_oe,
		input  data_bus, transfer_ack_n
	);
endinterface

// >>> hw/hbah_device.sv
// Purpose: device end of the strobe and acknowledge host port
// Assumes: host pins synchronous to REF_CLK
// Notes: decodes target, times the acknowledge, throttles data ram
`timescale 1ns/1ps
module hbah_device import hbah_pkg::*; #(
	parameter int FRAME_CYCLES = FRAME_CYC,        // throttle window
	parameter int ACCESS_LIMIT = FRAME_ACCESS_MAX  // data ram accesses per window
) (
	// clock and reset
	input  wire logic          REF_CLK,
	input  wire logic          RST_B,
	// host pins
	hbah_if.dev                BUS,
	// internal access port
	output logic               ACC_REQ,
	output logic               ACC_WR,
	output logic [1:0]         ACC_GRP,
	output hbah_target_e       ACC_TARGET,
	output logic [AW-1:0]      ACC_ADDR,
	output logic [DW-1:0]      ACC_WDATA,
	input  wire logic [DW-1:0] ACC_RDATA,
	// status
	output logic [GRPS-1:0]    THROTTLED
);
	localparam int FW = $clog2(FRAME_CYCLES + 1);  // frame counter width
	localparam int CW = $clog2(ACCESS_LIMIT + 1);  // access counter width

	// one-hot access states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,  // waiting for a strobe
		ST_WAIT = 4'b0010,  // acknowledge held high
		ST_XFER = 4'b0100,  // internal access issued
		ST_DONE = 4'b1000   // acknowledge low
	} hbah_dstate_e;

	hbah_dstate_e        state;      // access state
	logic [GRPS-1:0]     cs_n;       // per group internal strobe
	logic                cs_any;     // some strobe active
	logic [1:0]          sel_grp;    // active group number
	hbah_target_e        tgt;        // decoded target
	logic [TICK_W-1:0]   wait_len;   // wait for this access
	logic [TICK_W-1:0]   ticks;      // core cycles left
	logic [DIV_W-1:0]    div_cnt;    // core cycle divider
	logic                core_tick;  // one pulse per core cycle
	logic                start;      // access begins this cycle
	logic [FW-1:0]       frame_cnt;  // throttle window position
	logic                frame_end;  // window wraps
	logic [CW-1:0]       dram_cnt [GRPS];  // data ram accesses seen
	logic [GRPS-1:0]     heavy;      // group over its budget
	logic                ack_lvl;    // acknowledge level
	logic [GRPS-1:0]     ack_oe;     // acknowledge drive per group
	logic [DW-1:0]       dout;       // read data
	logic                dout_oe;    // read data driven

	// strobe per group, active only when both lines are low
	for (genvar g = 0; g < GRPS; g++) begin : g_cs
		assign cs_n[g] = BUS.group_select_n[g] | BUS.lower_data_strobe_n;
	end
	assign cs_any = ~&cs_n;
	assign start  = (state == ST_IDLE) && cs_any;

	// lowest active group wins; the host keeps only one low
	always_comb begin
		sel_grp = 2'h0;
		for (int i = GRPS - 1; i >= 0; i--) begin
			if (!cs_n[i]) begin
				sel_grp = 2'(i);
			end
		end
	end

	// target from the top address bits
	always_comb begin
		if (BUS.address[AW-1:REGION_LSB] == REGION_DRAM) begin
			tgt = TGT_DRAM;
		end else if (BUS.address[AW-1:REGION_LSB] == REGION_IMEM) begin
			tgt = TGT_IMEM;
		end else begin
			tgt = TGT_REG;
		end
	end

	// wait length per target and direction
	always_comb begin
		wait_len = WAIT_REG;
		case (tgt)
			TGT_IMEM: begin
				wait_len = BUS.read_not_write ? WAIT_IRD : WAIT_IWR;
			end
			TGT_DRAM: begin
				if (heavy[sel_grp]) begin
					wait_len = WAIT_THR;
				end else begin
					wait_len = BUS.read_not_write ? WAIT_DRD : WAIT_DWR;
				end
			end
			default: begin
				wait_len = WAIT_REG;
			end
		endcase
	end

	// core cycle divider, restarted at each access so waits are exact
	assign core_tick = (div_cnt == DIV_W'(CORE_DIV - 1));
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_cnt <= '0;
		end else if (start || core_tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// throttle window
	assign frame_end = (frame_cnt == FW'(FRAME_CYCLES - 1));
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			frame_cnt <= '0;
		end else if (frame_end) begin
			frame_cnt <= '0;
		end else begin
			frame_cnt <= frame_cnt + 1'b1;
		end
	end

	// data ram traffic per group; an access at the wrap is kept
	for (genvar g = 0; g < GRPS; g++) begin : g_thr
		logic hit;  // data ram access starts on this group
		assign hit = start && (tgt == TGT_DRAM) && (sel_grp == 2'(g));
		assign heavy[g] = (dram_cnt[g] >= CW'(ACCESS_LIMIT));
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B) begin
				dram_cnt[g] <= '0;
			end else if (frame_end) begin
				dram_cnt[g] <= hit ? CW'(1) : '0;
			end else if (hit && !heavy[g]) begin
				dram_cnt[g] <= dram_cnt[g] + 1'b1;
			end
		end
		// status view of the throttle
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B) begin
				THROTTLED[g] <= 1'b0;
			end else begin
				THROTTLED[g] <= heavy[g];
			end
		end
		// acknowledge driven from the cycle after own select goes low until the cycle after it rises
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B) begin
				ack_oe[g] <= 1'b0;
			end else begin
				ack_oe[g] <= ~BUS.group_select_n[g];
			end
		end
	end

	// access sequence
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state      <= ST_IDLE;
			ticks      <= '0;
			ACC_REQ    <= 1'b0;
			ACC_WR     <= 1'b0;
			ACC_GRP    <= 2'h0;
			ACC_TARGET <= TGT_REG;
			ACC_ADDR   <= '0;
			ACC_WDATA  <= '0;
			ack_lvl    <= 1'b1;
			dout       <= '0;
			dout_oe    <= 1'b0;
		end else begin
			ACC_REQ <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cs_any) begin
						// address and direction are stable under the strobe
						ACC_WR     <= ~BUS.read_not_write;
						ACC_GRP    <= sel_grp;
						ACC_TARGET <= tgt;
						ACC_ADDR   <= BUS.address;
						ticks      <= wait_len;
						ack_lvl    <= 1'b1;
						state      <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!cs_any) begin
						// host gave up early; drop the access
						state <= ST_IDLE;
					end else if (ticks == '0) begin
						// write data may arrive late, so take it at the end
						ACC_REQ   <= 1'b1;
						ACC_WDATA <= BUS.data_bus;
						state     <= ST_XFER;
					end else if (core_tick) begin
						ticks <= ticks - 1'b1;
					end
				end
				ST_XFER: begin
					if (!cs_any) begin
						state <= ST_IDLE;
					end else begin
						// data and falling acknowledge on the same edge
						dout    <= ACC_RDATA;
						dout_oe <= ~ACC_WR;
						ack_lvl <= 1'b0;
						state   <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (!cs_any) begin
						// low may go straight to released
						ack_lvl <= 1'b1;
						dout_oe <= 1'b0;
						state   <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// pin drive
	assign BUS.dev_ack     = ack_lvl;
	assign BUS.dev_ack_oe  = ack_oe;
	assign BUS.dev_data    = dout;
	assign BUS.dev_data_oe = dout_oe;
endmodule

// >>> hw/hbah_host.sv
// Purpose: host end that drives the strobe and acknowledge port
// Assumes: acknowledge synchronous to REF_CLK
// Notes: paces accesses per group; may ignore the acknowledge
`timescale 1ns/1ps
module hbah_host import hbah_pkg::*; #(
	parameter int FRAME_CYCLES = FRAME_CYC,        // pacing window
	parameter int ACCESS_LIMIT = FRAME_ACCESS_MAX  // accesses per group per window
) (
	// clock and reset
	input  wire logic          REF_CLK,
	input  wire logic          RST_B,
	// device pins
	hbah_if.host               BUS,
	// command side
	input  wire logic          CMD_VALID,
	input  wire logic          CMD_WR,
	input  wire logic [1:0]    CMD_GRP,
	input  wire logic [AW-1:0] CMD_ADDR,
	input  wire logic [DW-1:0] CMD_WDATA,
	input  wire logic          USE_ACK,
	output logic [GRPS-1:0]    CMD_READY,
	// response side
	output logic               RSP_VALID,
	output logic [DW-1:0]      RSP_RDATA
);
	localparam int FW = $clog2(FRAME_CYCLES + 1);
	localparam int CW = $clog2(ACCESS_LIMIT + 1);

	// one-hot host states
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,  // no access
		HS_SEL  = 3'b010,  // select low, pins set up
		HS_STRB = 3'b100   // strobe low, waiting
	} hbah_hstate_e;

	hbah_hstate_e    state;       // host state
	logic [1:0]      grp;         // group in use
	logic            is_rd;       // access is a read
	logic [HW_W-1:0] wcnt;        // fixed wait counter
	logic [HG_W-1:0] gap;         // cycles since last release
	logic [FW-1:0]   frame_cnt;   // window position
	logic            frame_end;   // window wraps
	logic [CW-1:0]   used [GRPS]; // accesses this window
	logic            take;        // command accepted
	logic            finish;      // access ends this cycle

	assign take = (state == HS_IDLE) && CMD_VALID && CMD_READY[CMD_GRP];
	// without the acknowledge, a fixed wait covers the device unless data ram is throttled
	assign finish = (state == HS_STRB) &&
		(USE_ACK ? !BUS.transfer_ack_n[grp] : (wcnt == HW_W'(HOST_WAIT_CYC)));
	assign frame_end = (frame_cnt == FW'(FRAME_CYCLES - 1));

	// pacing window
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			frame_cnt <= '0;
		end else if (frame_end) begin
			frame_cnt <= '0;
		end else begin
			frame_cnt <= frame_cnt + 1'b1;
		end
	end

	// spacing after each access, saturating; one gap covers all groups
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			gap <= HG_W'(HOST_GAP_CYC);
		end else if (finish) begin
			gap <= '0;
		end else if (gap != HG_W'(HOST_GAP_CYC)) begin
			gap <= gap + 1'b1;
		end
	end

	// per group budget and readiness
	for (genvar g = 0; g < GRPS; g++) begin : g_pace
		logic hit;  // access to this group taken
		assign hit = take && (CMD_GRP == 2'(g));
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B) begin
				used[g] <= '0;
			end else if (frame_end) begin
				used[g] <= hit ? CW'(1) : '0;
			end else if (hit) begin
				used[g] <= used[g] + 1'b1;
			end
		end
		always_ff @(posedge REF_CLK or negedge RST_B) begin
			if (!RST_B) begin
				CMD_READY[g] <= 1'b0;
			end else begin
				CMD_READY[g] <= (state == HS_IDLE) && !take && !finish &&
					(gap == HG_W'(HOST_GAP_CYC)) && (used[g] < CW'(ACCESS_LIMIT));
			end
		end
	end

	// access sequence and pins
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state                   <= HS_IDLE;
			grp                     <= 2'h0;
			is_rd                   <= 1'b0;
			wcnt                    <= '0;
			RSP_VALID               <= 1'b0;
			RSP_RDATA               <= '0;
			BUS.group_select_n      <= {GRPS{1'b1}};
			BUS.lower_data_strobe_n <= 1'b1;
			BUS.read_not_write      <= 1'b1;
			BUS.address             <= '0;
			BUS.host_data           <= '0;
			BUS.host_data_oe        <= 1'b0;
		end else begin
			RSP_VALID <= 1'b0;
			case (state)
				HS_IDLE: begin
					if (take) begin
						grp                <= CMD_GRP;
						is_rd              <= !CMD_WR;
						BUS.group_select_n <= ~(GRPS'(1) << CMD_GRP);
						BUS.read_not_write <= !CMD_WR;
						BUS.address        <= CMD_ADDR;
						BUS.host_data      <= CMD_WDATA;
						BUS.host_data_oe   <= CMD_WR;
						state              <= HS_SEL;
					end
				end
				HS_SEL: begin
					BUS.lower_data_strobe_n <= 1'b0;
					wcnt                    <= '0;
					state                   <= HS_STRB;
				end
				HS_STRB: begin
					if (finish) begin
						RSP_VALID               <= 1'b1;
						RSP_RDATA               <= is_rd ? BUS.data_bus : '0;
						BUS.group_select_n      <= {GRPS{1'b1}};
						BUS.lower_data_strobe_n <= 1'b1;
						BUS.host_data_oe        <= 1'b0;
						state                   <= HS_IDLE;
					end else if (wcnt != HW_W'(HOST_WAIT_CYC)) begin
						wcnt <= wcnt + 1'b1;
					end
				end
				default: begin
					state <= HS_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> dv/hbah_props.sv
// Purpose: timing checks on the host port wires
// Assumes: all wires sampled on REF_CLK rising edge
// Notes: wait bounds are one core cycle wide except imem write at two and dram at 89; throttling hides in the dram upper bound
`timescale 1ns/1ps
module hbah_props import hbah_pkg::*; (
	// clock and reset
	input wire logic            REF_CLK,
	input wire logic            RST_B,
	// host driven wires
	input wire logic [GRPS-1:0] group_select_n,
	input wire logic            lower_data_strobe_n,
	input wire logic            read_not_write,
	input wire logic [AW-1:0]   address,
	// device driven wires
	input wire logic [DW-1:0]   dev_data,
	input wire logic            dev_data_oe,
	input wire logic            dev_ack,
	input wire logic [GRPS-1:0] dev_ack_oe,
	input wire logic [DW-1:0]   data_bus
);
	localparam int CC = CORE_DIV; // clocks per core cycle
	logic       cs;   // internal strobe, select and data strobe both low
	logic [1:0] rgn;  // target region of the held address
	logic [9:0] wcnt; // clocks of this access with ack still high
	logic       imem; // instruction memory target
	logic       dram; // data ram target
	assign cs   = !lower_data_strobe_n && (group_select_n != {GRPS{1'b1}});
	assign rgn  = address[AW-1:REGION_LSB];
	assign imem = (rgn == 2'h2);
	assign dram = (rgn == 2'h3);
	// wait counter, cleared between accesses
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wcnt <= '0;
		end else if (!cs) begin
			wcnt <= '0;
		end else if (dev_ack) begin
			wcnt <= wcnt + 10'h001;
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	// ack held high no longer than hi, and falls only after lo
	property p_wait(logic sel, int lo, int hi);
		cs && sel |-> (dev_ack && wcnt < hi) || (!dev_ack && (!$fell(dev_ack) || wcnt > lo));
	endproperty
	sequence s_acked;
		cs && !dev_ack ##1 cs;
	endsequence
	sequence s_idle2;
		!cs ##1 !cs;
	endsequence
	property p_reg_ack;   p_wait(!imem && !dram, 0, CC); endproperty
	property p_imem_rd;   p_wait(imem && read_not_write, 6 * CC, 7 * CC); endproperty
	property p_imem_wr;   p_wait(imem && !read_not_write, 5 * CC, 7 * CC); endproperty
	property p_dram_rd;   p_wait(dram && read_not_write, 9 * CC, 98 * CC); endproperty
	property p_dram_wr;   p_wait(dram && !read_not_write, 9 * CC, 98 * CC); endproperty
	property p_ack_oe;    dev_ack_oe == ~$past(group_select_n); endproperty
	property p_cs_or;     $fell(dev_ack) |-> $past(cs); endproperty
	property p_rd_data;   $fell(dev_ack) && read_not_write |-> dev_data_oe && data_bus == dev_data; endproperty
	property p_ack_hold;  s_acked |-> !dev_ack; endproperty
	property p_release;   s_idle2 |-> dev_ack && !dev_data_oe; endproperty
	property p_one_grp;   $onehot0(~group_select_n); endproperty
	a_reg_ack:  assert property (p_reg_ack)  else $error("register ack late");
	a_imem_rd:  assert property (p_imem_rd)  else $error("imem read wait wrong");
	a_imem_wr:  assert property (p_imem_wr)  else $error("imem write wait wrong");
	a_dram_rd:  assert property (p_dram_rd)  else $error("dram read wait wrong");
	a_dram_wr:  assert property (p_dram_wr)  else $error("dram write wait wrong");
	a_ack_oe:   assert property (p_ack_oe)   else $error("ack enable not following select");
	a_cs_or:    assert property (p_cs_or)    else $error("ack without strobe");
	a_rd_data:  assert property (p_rd_data)  else $error("read data late");
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
	a_release:  assert property (p_release)  else $error("ack not released");
	a_one_grp:  assert property (p_one_grp)  else $error("two selects low");
endmodule

// >>> dv/hbah_tb.sv
// Purpose: self checking bench joining host and device ends
// Assumes: short throttle window, device budget of one dram access
// Notes: device storage and reference model both live here
`timescale 1ns/1ps
module host_bus_ack_handshake_tb import hbah_pkg::*; ;
	localparam int FRAMES = 200; // short window keeps the run brief
	logic            ref_clk, rst_b;
	logic            acc_req, acc_wr, cmd_valid, cmd_wr, use_ack, rsp_valid, thr_seen;
	logic [1:0]      acc_grp, cmd_grp;
	hbah_target_e    acc_target;
	logic [AW-1:0]   acc_addr, cmd_addr, a;
	logic [DW-1:0]   acc_wdata, acc_rdata, cmd_wdata, rsp_rdata, d;
	logic [GRPS-1:0] throttled, cmd_ready;
	logic [DW-1:0]   store [0:(1<<AW)-1]; // device side storage
	int              ref_mem [0:(1<<AW)-1]; // reference contents
	int              exp_q [$];            // expected internal accesses
	int              errors, comparisons, lat, max_lat, rnd;
	hbah_if i_hbah_if ();
	hbah_device #(.FRAME_CYCLES(FRAMES), .ACCESS_LIMIT(1)) i_hbah_device (
		.REF_CLK(ref_clk), .RST_B(rst_b), .BUS(i_hbah_if.dev), .ACC_REQ(acc_req), .ACC_WR(acc_wr),
		.ACC_GRP(acc_grp), .ACC_TARGET(acc_target), .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata),
		.ACC_RDATA(acc_rdata), .THROTTLED(throttled));
	hbah_host #(.FRAME_CYCLES(FRAMES), .ACCESS_LIMIT(4)) i_hbah_host (
		.REF_CLK(ref_clk), .RST_B(rst_b), .BUS(i_hbah_if.host), .CMD_VALID(cmd_valid), .CMD_WR(cmd_wr),
		.CMD_GRP(cmd_grp), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .USE_ACK(use_ack),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
	hbah_props i_hbah_props (
		.REF_CLK(ref_clk), .RST_B(rst_b), .group_select_n(i_hbah_if.group_select_n),
		.lower_data_strobe_n(i_hbah_if.lower_data_strobe_n), .read_not_write(i_hbah_if.read_not_write),
		.address(i_hbah_if.address), .dev_data(i_hbah_if.dev_data), .dev_data_oe(i_hbah_if.dev_data_oe),
		.dev_ack(i_hbah_if.dev_ack), .dev_ack_oe(i_hbah_if.dev_ack_oe), .data_bus(i_hbah_if.data_bus));
	// storage answers combinationally on the held address
	assign acc_rdata = store[acc_addr];
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// one command through the host; called at a falling edge
	task automatic do_cmd(input logic wr, input logic [1:0] g, input logic [AW-1:0] ad,
		input logic [DW-1:0] dt, input logic ua);
		int n;
		logic [2:0] t;
		n = 0;
		while (cmd_ready[g] !== 1'b1 && n < 2000) begin
			@(negedge ref_clk);
			n++;
		end
		t = (ad[10:9] == 2'h3) ? 3'h4 : ((ad[10:9] == 2'h2) ? 3'h2 : 3'h1);
		exp_q.push_back(int'({7'h00, wr, g, t, ad, wr ? dt : 8'h00}));
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_wr    <= wr;
		cmd_grp   <= g;
		cmd_addr  <= ad;
		cmd_wdata <= dt;
		use_ack   <= ua;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge ref_clk);
			lat++;
		end while (rsp_valid !== 1'b1 && lat < 1000);
		if (lat > max_lat) max_lat = lat;
		chk("response seen", 1, rsp_valid);
		// the host must hold every group off right after an access
		chk("ready in gap", 4'h0, cmd_ready);
		if (!ua) chk("fixed wait", HOST_WAIT_CYC + 3, lat);
		if (!wr) chk("read data", ref_mem[ad][7:0], rsp_rdata);
		if (wr) ref_mem[ad] = int'(dt);
	endtask
	// internal access port compared with the expected queue
	always @(posedge ref_clk) begin
		if (throttled[0] === 1'b1) thr_seen <= 1'b1;
		if (acc_req === 1'b1) begin
			if (acc_wr === 1'b1) store[acc_addr] <= acc_wdata;
			if (exp_q.size() == 0) chk("spare access", 0, 1);
			else chk("access", exp_q.pop_front(), {7'h00, acc_wr, acc_grp, acc_target, acc_addr,
				acc_wr ? acc_wdata : 8'h00});
		end
	end
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// watchdog sized well past the longest throttled sequence
	initial begin
		repeat (60000) @(posedge ref_clk);
		errors++;
		wrap_up();
	end
	initial begin
		rst_b = 1'b0; cmd_valid = 1'b0; cmd_wr = 1'b0; cmd_grp = 2'h0; use_ack = 1'b1;
		cmd_addr = '0; cmd_wdata = 8'h00; errors = 0; comparisons = 0; max_lat = 0; thr_seen = 1'b0;
		for (int i = 0; i < (1 << AW); i++) begin
			store[i] = 8'(i) ^ 8'h5a;
			ref_mem[i] = int'(8'(i) ^ 8'h5a);
		end
		rnd = $urandom(21115);
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		// write then read back on every region, group and direction
		for (int k = 0; k < 8; k++) begin
			a = {2'(k), 9'($urandom)};
			d = 8'($urandom);
			do_cmd(1'b1, 2'(k + k / 4), a, d, 1'b1);
			do_cmd(1'b0, 2'(k + k / 4), a, 8'h00, 1'b1);
		end
		// host ignoring the ack on register and instruction targets
		for (int k = 0; k < 4; k++) begin
			a = {(k > 1) ? 2'h2 : 2'h1, 9'($urandom)};
			do_cmd(1'(k), 2'(k), a, 8'($urandom), 1'b0);
		end
		// dram burst on one group exhausts its budget; four accesses
		// so two of them always share one window whatever the phase
		max_lat = 0;
		repeat (4) do_cmd(1'b0, 2'h0, {2'h3, 9'($urandom)}, 8'h00, 1'b1);
		chk("throttled wait", 1, max_lat >= 97 * CORE_DIV);
		chk("throttled flag", 1, thr_seen);
		// a quiet group still sees the short dram wait
		repeat (2 * FRAMES) @(negedge ref_clk);
		chk("throttle cleared", 4'h0, throttled);
		do_cmd(1'b0, 2'h3, {2'h3, 9'($urandom)}, 8'h00, 1'b1);
		chk("plain dram wait", 1, lat < 34 * CORE_DIV);
		chk("accesses left", 0, exp_q.size());
		wrap_up();
	end
endmodule
